//--- rtl/strap_pkg.sv
// Purpose: shared types and constants for the power-on strap latch
// Assumes: one 20 MHz clock, strap pins asynchronous to it
// Notes:   strap pin levels are raw pin levels; decoding is in the top
package strap_pkg;

  // ==========================================================================
  // strap pins and decoded configuration
  typedef struct packed {
    logic       self_test_strap;
    logic       service_proc_boot_strap;
    logic       trusted_platform_strap;
    logic       powerup_halt_strap;       // low means halt
    logic       firmware_agent_strap;
    logic       trusted_agent_strap;
    logic       safe_mode_strap;
    logic [1:0] socket_index_strap;
  } strap_pins_t;

  localparam int STRAP_W    = 9;
  localparam int PG_GROUP_W = 8;          // all straps but self test

  // internal pull levels seen when the board leaves a strap floating
  localparam strap_pins_t STRAP_PULL = '{
    self_test_strap:         1'b1,
    service_proc_boot_strap: 1'b0,
    trusted_platform_strap:  1'b1,
    powerup_halt_strap:      1'b1,
    firmware_agent_strap:    1'b0,
    trusted_agent_strap:     1'b0,
    safe_mode_strap:         1'b0,
    socket_index_strap:      2'h0
  };

  typedef struct packed {
    logic       fault_resilient_boot;     // output tri-state option
    logic       builtin_self_test;
    logic       service_proc_boot;
    logic       trusted_platform;
    logic       powerup_halt;
    logic       firmware_agent;
    logic       trusted_agent;
    logic       safe_mode;
    logic [1:0] socket_index;
  } poweron_config_t;

  localparam int CFG_W = 10;

  // ==========================================================================
  // synchroniser vector: {plat_rst_n, pwr_good, core_rst, thermal, straps}
  localparam int SYNC_W = 13;
  localparam logic [12:0] SYNC_RST = {1'b0, 1'b0, 1'b0, 1'b1, STRAP_PULL};
  localparam logic THERMAL_RST = 1'b1;    // pin idle high, not asserted

  // ==========================================================================
  // boot sequence states
  typedef enum logic [4:0] {
    SEQ_WAIT      = 5'h01,
    SEQ_DECIDE    = 5'h02,
    SEQ_SELF_TEST = 5'h04,
    SEQ_HALT      = 5'h08,
    SEQ_RUN       = 5'h10
  } seq_state_t;

  // ==========================================================================
  // register port
  localparam int ADDR_W = 8;
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } reg_req_t;

  localparam logic [7:0] REG_CONFIG   = 8'h00;
  localparam logic [7:0] REG_SEQ      = 8'h04;
  localparam logic [7:0] REG_CONTROL  = 8'h08;
  localparam logic [7:0] REG_CAPTURES = 8'h0C;

  localparam int CTRL_HALT_RELEASE = 0;   // write one: leave halt
  localparam int SEQ_PLAT_BIT      = 8;
  localparam int SEQ_PG_BIT        = 9;
  localparam int SEQ_CORE_BIT      = 10;
  localparam logic [7:0] CAPTURES_RST = 8'h00;

endpackage : strap_pkg

//--- rtl/strap_sync.sv
// Purpose: two-flop synchroniser for a vector of asynchronous pins
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
module strap_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // ==========================================================================
  // two stages; metastability settles in stage1
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1   <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : strap_sync

//--- rtl/strap_capture.sv
// Purpose: holding register for one group of straps
// Assumes: load is a one-cycle event pulse on clk
// Notes:   value only changes on load, so it is frozen between events
module strap_capture #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // ==========================================================================
  // capture on the event, hold otherwise
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= RST_VAL;
    else if (load)
      q <= d;
  end

endmodule : strap_capture

//--- rtl/poweron_strap_latch.sv
// Purpose: latch power-on straps and run the early boot sequence
// Assumes: pins asynchronous to clk; register port on clk
// Notes:   reads return data in the cycle after the read strobe

// Functional notes
// - straps captured on reset release or power-good rise
// - captured options change only on new event
// - thermal pin at platform reset release selects tri-state
// - self test sampled at both reset releases
// - other straps sampled on power-good rise
// - halt strap stops sequence until probe releases
// - service-processor boot strap selects that mode
// - firmware-agent strap makes device bootable agent
// - safe-mode strap selects safe-mode boot
// - floating straps take their internal pull level
module poweron_strap_latch (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       platform_reset_n_pin,
  input  wire logic                       power_good_in,
  input  wire logic                       core_reset_pin,
  input  wire logic                       thermal_hot_pin,
  input  wire strap_pkg::strap_pins_t     strap_pins,
  input  wire logic [8:0]                 strap_driven,
  input  wire logic                       self_test_done,
  input  wire strap_pkg::reg_req_t        reg_req,
  output logic      [31:0]                reg_rdata,
  output strap_pkg::poweron_config_t      config_out,
  output logic                            output_tristate_en,
  output logic                            builtin_self_test_run,
  output logic                            powerup_halted,
  output logic                            boot_proceed
);

  // ==========================================================================
  // pad resolution: an undriven strap reads its pull level
  wire strap_pkg::strap_pins_t strap_level;
  assign strap_level = (strap_pins & strap_driven)
                     | (strap_pkg::STRAP_PULL & ~strap_driven);

  // ==========================================================================
  // synchronisers; straps share the latency of the latching signals so
  // the value captured on an edge is the one present at that edge
  logic [strap_pkg::SYNC_W-1:0] sync_vec;

  strap_sync #(
    .WIDTH   (strap_pkg::SYNC_W),
    .RST_VAL (strap_pkg::SYNC_RST)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({platform_reset_n_pin, power_good_in, core_reset_pin,
                thermal_hot_pin, strap_level}),
    .sync_out (sync_vec)
  );

  wire                         plat_rst_n_s;
  wire                         pwr_good_s;
  wire                         core_rst_s;
  wire                         thermal_s;
  wire strap_pkg::strap_pins_t strap_s;
  assign plat_rst_n_s = sync_vec[12];
  assign pwr_good_s   = sync_vec[11];
  assign core_rst_s   = sync_vec[10];
  assign thermal_s    = sync_vec[9];
  assign strap_s      = sync_vec[8:0];

  // ==========================================================================
  // edge detection on the synchronised latching signals only
  logic plat_rst_n_d;
  logic pwr_good_d;
  logic core_rst_d;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      plat_rst_n_d <= 1'b0;
      pwr_good_d   <= 1'b0;
      core_rst_d   <= 1'b0;
    end
    else
    begin
      plat_rst_n_d <= plat_rst_n_s;
      pwr_good_d   <= pwr_good_s;
      core_rst_d   <= core_rst_s;
    end
  end

  // reset-low flops mean a platform-reset or power-good pin already high after rst still gives an event
  wire rst_release_ev;
  wire pg_rise_ev;
  wire core_release_ev;
  wire any_capture_ev;
  assign rst_release_ev  = plat_rst_n_s & ~plat_rst_n_d;
  assign pg_rise_ev      = pwr_good_s & ~pwr_good_d;
  assign core_release_ev = ~core_rst_s & core_rst_d;
  assign any_capture_ev  = rst_release_ev | pg_rise_ev | core_release_ev;

  // ==========================================================================
  // capture groups, one per latching signal set
  logic                                thermal_cap;
  logic                                self_test_cap;
  logic [strap_pkg::PG_GROUP_W-1:0]    pg_group_cap;
  wire                                 self_test_load;
  assign self_test_load = rst_release_ev | core_release_ev;

  strap_capture #(
    .WIDTH   (1),
    .RST_VAL (strap_pkg::THERMAL_RST)
  ) u_cap_thermal (
    .clk  (clk),
    .rst  (rst),
    .load (rst_release_ev),
    .d    (thermal_s),
    .q    (thermal_cap)
  );

  strap_capture #(
    .WIDTH   (1),
    .RST_VAL (strap_pkg::STRAP_PULL.self_test_strap)
  ) u_cap_self_test (
    .clk  (clk),
    .rst  (rst),
    .load (self_test_load),
    .d    (strap_s.self_test_strap),
    .q    (self_test_cap)
  );

  strap_capture #(
    .WIDTH   (strap_pkg::PG_GROUP_W),
    .RST_VAL (strap_pkg::STRAP_PULL[strap_pkg::PG_GROUP_W-1:0])
  ) u_cap_pg (
    .clk  (clk),
    .rst  (rst),
    .load (pg_rise_ev),
    .d    (strap_s[strap_pkg::PG_GROUP_W-1:0]),
    .q    (pg_group_cap)
  );

  // ==========================================================================
  // decode raw captured pin levels into option meanings
  wire strap_pkg::strap_pins_t cap_pins;
  assign cap_pins = {self_test_cap, pg_group_cap};

  // thermal and halt pins are active low
  assign config_out.fault_resilient_boot = ~thermal_cap;
  assign config_out.builtin_self_test    = cap_pins.self_test_strap;
  assign config_out.service_proc_boot    =
           cap_pins.service_proc_boot_strap;
  assign config_out.trusted_platform     = cap_pins.trusted_platform_strap;
  assign config_out.powerup_halt         = ~cap_pins.powerup_halt_strap;
  assign config_out.firmware_agent       =
           cap_pins.firmware_agent_strap;
  assign config_out.trusted_agent        = cap_pins.trusted_agent_strap;
  assign config_out.safe_mode            = cap_pins.safe_mode_strap;
  assign config_out.socket_index         = cap_pins.socket_index_strap;

  // tri-state request for fault-resilient boot comes straight from a flop
  assign output_tristate_en = config_out.fault_resilient_boot;

  // ==========================================================================
  // register port decode
  wire hit_config;
  wire hit_seq;
  wire hit_control;
  wire hit_captures;
  wire halt_release;
  assign hit_config   = reg_req.addr == strap_pkg::REG_CONFIG;
  assign hit_seq      = reg_req.addr == strap_pkg::REG_SEQ;
  assign hit_control  = reg_req.addr == strap_pkg::REG_CONTROL;
  assign hit_captures = reg_req.addr == strap_pkg::REG_CAPTURES;
  assign halt_release = reg_req.wr & hit_control
                      & reg_req.wdata[strap_pkg::CTRL_HALT_RELEASE];

  // ==========================================================================
  // boot sequence: wait for reset release, optional self test, optional
  // halt for the debug probe, then proceed
  strap_pkg::seq_state_t state;
  strap_pkg::seq_state_t next_state;
  wire                   in_reset;
  wire                   start_ev;
  assign in_reset = ~plat_rst_n_s | core_rst_s;
  assign start_ev = (rst_release_ev & ~core_rst_s)
                  | (core_release_ev & plat_rst_n_s);

  // decide one cycle after the event so the capture flops are settled
  always_comb
  begin
    next_state = state;
    case (state)
      strap_pkg::SEQ_WAIT:
        if (start_ev)
          next_state = strap_pkg::SEQ_DECIDE;
      strap_pkg::SEQ_DECIDE:
        if (config_out.builtin_self_test)
          next_state = strap_pkg::SEQ_SELF_TEST;
        else if (config_out.powerup_halt)
          next_state = strap_pkg::SEQ_HALT;
        else
          next_state = strap_pkg::SEQ_RUN;
      strap_pkg::SEQ_SELF_TEST:
        if (self_test_done)
          next_state = config_out.powerup_halt ? strap_pkg::SEQ_HALT
                                               : strap_pkg::SEQ_RUN;
      strap_pkg::SEQ_HALT:
        if (halt_release)
          next_state = strap_pkg::SEQ_RUN;
      strap_pkg::SEQ_RUN:
        next_state = strap_pkg::SEQ_RUN;
      default:
        next_state = strap_pkg::SEQ_WAIT;
    endcase
    if (in_reset)
      next_state = strap_pkg::SEQ_WAIT;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state <= strap_pkg::SEQ_WAIT;
    else
      state <= next_state;
  end

  assign builtin_self_test_run = state == strap_pkg::SEQ_SELF_TEST;
  assign powerup_halted        = state == strap_pkg::SEQ_HALT;
  assign boot_proceed          = state == strap_pkg::SEQ_RUN;

  // ==========================================================================
  // capture event counter; wraps, lets software spot a re-latch
  logic [7:0] capture_count;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      capture_count <= strap_pkg::CAPTURES_RST;
    else if (any_capture_ev)
      capture_count <= capture_count + 8'h01;
  end

  // ==========================================================================
  // read mux; unmapped addresses and control read as zero
  wire [31:0] seq_word;
  wire [31:0] next_rdata;
  assign seq_word = {21'h000000, core_rst_s, pwr_good_s, plat_rst_n_s,
                     3'h0, state};
  assign next_rdata = !reg_req.rd   ? 32'h00000000
                    : hit_config   ? {22'h000000, config_out}
                    : hit_seq      ? seq_word
                    : hit_captures ? {24'h000000, capture_count}
                    : 32'h00000000;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 32'h00000000;
    else
      reg_rdata <= next_rdata;
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  capture_on_pg_a: assert property (
    pg_rise_ev |=> config_out.socket_index
                   == $past(strap_s.socket_index_strap))
    else $error("socket index not captured on power-good rise");

  config_hold_a: assert property (
    !any_capture_ev |=> $stable(config_out))
    else $error("configuration changed without a latching event");

  tristate_latch_a: assert property (
    rst_release_ev |=> output_tristate_en == !$past(thermal_s))
    else $error("tri-state option not latched at reset release");

  self_test_core_a: assert property (
    core_release_ev |=> config_out.builtin_self_test
                        == $past(strap_s.self_test_strap))
    else $error("self test strap not latched at core reset release");

  pg_group_a: assert property (
    pg_rise_ev |=> config_out.trusted_platform
                   == $past(strap_s.trusted_platform_strap)
                && config_out.trusted_agent
                   == $past(strap_s.trusted_agent_strap)
                && config_out.powerup_halt
                   == !$past(strap_s.powerup_halt_strap))
    else $error("power-good strap group not latched");

  halt_hold_a: assert property (
    powerup_halted && !halt_release && !in_reset |=> powerup_halted)
    else $error("halt left without release");

  halt_enter_a: assert property (
    state == strap_pkg::SEQ_DECIDE && !in_reset
    && !config_out.builtin_self_test && config_out.powerup_halt
    |=> powerup_halted)
    else $error("halt strap did not stop the sequence");

  svc_boot_a: assert property (
    pg_rise_ev && strap_s.service_proc_boot_strap
    |=> config_out.service_proc_boot)
    else $error("service processor boot mode not entered");

  fw_agent_a: assert property (
    pg_rise_ev ##1 !any_capture_ev [*3]
    |-> config_out.firmware_agent == $past(strap_s.firmware_agent_strap, 3))
    else $error("firmware agent option lost");

  safe_mode_a: assert property (
    pg_rise_ev && !strap_s.safe_mode_strap |=> !config_out.safe_mode)
    else $error("safe mode selected with strap low");

  pull_default_a: assert property (
    $past(strap_driven, 2) == 9'h000 |-> strap_s == strap_pkg::STRAP_PULL)
    else $error("floating straps not at pull level");

  release_edge_a: assert property (
    rst_release_ev |-> $past(platform_reset_n_pin, 2)
                    && !$past(platform_reset_n_pin, 3))
    else $error("reset release event not two cycles after pin");

  // self test is also latched by the platform release, not only core
  self_test_plat_a: assert property (
    rst_release_ev |=> config_out.builtin_self_test
                       == $past(strap_s.self_test_strap))
    else $error("self test strap not latched at reset release");

  tristate_hold_a: assert property (
    !rst_release_ev |=> $stable(output_tristate_en))
    else $error("tri-state option changed without reset release");

  cover_pg_c:     cover property (pg_rise_ev);
  cover_self_c:   cover property (builtin_self_test_run ##1 boot_proceed);
  cover_halt_c:   cover property (powerup_halted ##1 boot_proceed);
  cover_core_c:   cover property (core_release_ev);
  cover_tri_c:    cover property (rst_release_ev && !thermal_s);

endmodule : poweron_strap_latch

//--- tb/board_strap_model.sv
// Purpose: board strap logic driving the latch's pins
// Assumes: tasks called from the bench after a clock edge
// Notes:   floating straps carry no board level; the pad pull is on die
module board_strap_model (
  input  wire logic               clk,
  output logic                    platform_reset_n_pin,
  output logic                    power_good_in,
  output logic                    core_reset_pin,
  output logic                    thermal_hot_pin,
  output strap_pkg::strap_pins_t  strap_pins,
  output logic [8:0]              strap_driven
);
  timeunit 1ns;
  timeprecision 1ns;

  strap_pkg::strap_pins_t want;
  logic [8:0]             drive;

  // ==========================================================================
  // pin levels
  // an undriven pad shows the opposite of its pull so a missed pull shows
  assign strap_pins   = strap_pkg::strap_pins_t'((want & drive)
                        | (~strap_pkg::STRAP_PULL & ~drive));
  assign strap_driven = drive;

  // latching signals start low so no event fires out of reset
  initial
  begin
    platform_reset_n_pin = 1'b0;
    power_good_in        = 1'b0;
    core_reset_pin       = 1'b0;
    thermal_hot_pin      = 1'b1;
    want                 = '0;
    drive                = '1;
  end

  // ==========================================================================
  // sequences
  task automatic latch(input int k, input logic act);
    case (k)
      0:       power_good_in <= ~act;
      1:       platform_reset_n_pin <= ~act;
      default: core_reset_pin <= act;
    endcase
  endtask : latch

  // straps move only while the latching signal is held active
  task automatic event_cycle(input int k, input strap_pkg::strap_pins_t v,
                             input logic [8:0] d, input logic th);
    @(posedge clk);
    latch(k, 1'b1);
    repeat (3) @(posedge clk);
    want            <= v;
    drive           <= d;
    thermal_hot_pin <= th;
    repeat (4) @(posedge clk);
    latch(k, 1'b0);
    repeat (6) @(posedge clk);
  endtask : event_cycle

  // strap noise with no latching edge, for the hold checks
  task automatic set_straps(input strap_pkg::strap_pins_t v,
                            input logic [8:0] d, input logic th);
    @(posedge clk);
    want            <= v;
    drive           <= d;
    thermal_hot_pin <= th;
  endtask : set_straps
endmodule : board_strap_model

//--- tb/test_poweron_strap_latch.sv
// Purpose: self-checking bench for the power-on strap latch
// Assumes: 20 MHz clock, board model drives every pin
// Notes:   expectations come from bench functions, never from outputs
`define CHK(what, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("ERROR %s expected %h seen %h", what, exp, got); \
    end \
  end

module test_poweron_strap_latch;
  timeunit 1ns;
  timeprecision 1ns;

  logic                       clk;
  logic                       rst;
  logic                       platform_reset_n_pin;
  logic                       power_good_in;
  logic                       core_reset_pin;
  logic                       thermal_hot_pin;
  strap_pkg::strap_pins_t     strap_pins;
  strap_pkg::strap_pins_t     pick;
  logic [8:0]                 strap_driven;
  logic [8:0]                 drv;
  logic                       self_test_done;
  strap_pkg::reg_req_t        reg_req;
  logic [31:0]                reg_rdata;
  logic [31:0]                rd_val;
  strap_pkg::poweron_config_t config_out;
  strap_pkg::poweron_config_t exp_cfg;
  logic                       output_tristate_en;
  logic                       builtin_self_test_run;
  logic                       powerup_halted;
  logic                       boot_proceed;
  logic                       th;
  int                         bad_count;
  int                         total_checks;
  int                         seed;
  int                         kind;
  int                         caps;

  poweron_strap_latch poweron_strap_latch_i (
    .clk                   (clk),
    .rst                   (rst),
    .platform_reset_n_pin  (platform_reset_n_pin),
    .power_good_in         (power_good_in),
    .core_reset_pin        (core_reset_pin),
    .thermal_hot_pin       (thermal_hot_pin),
    .strap_pins            (strap_pins),
    .strap_driven          (strap_driven),
    .self_test_done        (self_test_done),
    .reg_req               (reg_req),
    .reg_rdata             (reg_rdata),
    .config_out            (config_out),
    .output_tristate_en    (output_tristate_en),
    .builtin_self_test_run (builtin_self_test_run),
    .powerup_halted        (powerup_halted),
    .boot_proceed          (boot_proceed)
  );

  board_strap_model board_strap_model_i (
    .clk                  (clk),
    .platform_reset_n_pin (platform_reset_n_pin),
    .power_good_in        (power_good_in),
    .core_reset_pin       (core_reset_pin),
    .thermal_hot_pin      (thermal_hot_pin),
    .strap_pins           (strap_pins),
    .strap_driven         (strap_driven)
  );

  // ==========================================================================
  // expectations
  // level the device sees: board drive where driven, pull level elsewhere
  function automatic strap_pkg::strap_pins_t eff(strap_pkg::strap_pins_t p,
                                                 logic [8:0] d);
    return strap_pkg::strap_pins_t'((p & d) | (strap_pkg::STRAP_PULL & ~d));
  endfunction : eff

  // kind 0 power-good rise, 1 platform release, 2 core-only release
  function automatic strap_pkg::poweron_config_t next_cfg(
    strap_pkg::poweron_config_t c, int k, strap_pkg::strap_pins_t p,
    logic t);
    strap_pkg::poweron_config_t n;
    n = c;
    if (k == 0)
    begin
      n.service_proc_boot = p.service_proc_boot_strap;
      n.trusted_platform  = p.trusted_platform_strap;
      n.powerup_halt      = ~p.powerup_halt_strap;
      n.firmware_agent    = p.firmware_agent_strap;
      n.trusted_agent     = p.trusted_agent_strap;
      n.safe_mode         = p.safe_mode_strap;
      n.socket_index      = p.socket_index_strap;
    end
    else
      n.builtin_self_test = p.self_test_strap;
    if (k == 1)
      n.fault_resilient_boot = ~t;
    return n;
  endfunction : next_cfg

  // ==========================================================================
  // register port and boot walk
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
  endtask : reg_write

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    reg_req <= '0;
    @(negedge clk);
    d = reg_rdata;
  endtask : reg_read

  task automatic settle();
    int n;
    n = 0;
    while ((builtin_self_test_run | powerup_halted | boot_proceed) !== 1'b1
           && n < 20)
    begin
      @(negedge clk);
      n++;
    end
  endtask : settle

  task automatic boot_walk();
    settle();
    `CHK("self_test_run", exp_cfg.builtin_self_test, builtin_self_test_run);
    if (builtin_self_test_run === 1'b1)
    begin
      @(posedge clk);
      self_test_done <= 1'b1;
      @(posedge clk);
      self_test_done <= 1'b0;
      @(negedge clk);
      settle();
    end
    `CHK("halted", exp_cfg.powerup_halt, powerup_halted);
    if (powerup_halted === 1'b1)
    begin
      reg_write(strap_pkg::REG_CONTROL, 32'h1);
      @(negedge clk);
    end
    `CHK("proceed", 1'b1, boot_proceed);
  endtask : boot_walk

  task automatic close_out();
    if (bad_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // ==========================================================================
  // clock, watchdog, main sequence
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // the whole run needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end

  initial
  begin
    seed           = 9556;
    bad_count      = 0;
    total_checks   = 0;
    caps           = 0;
    rst            = 1'b1;
    self_test_done = 1'b0;
    reg_req        = '0;
    exp_cfg        = strap_pkg::poweron_config_t'(10'h140);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK("cfg_reset", exp_cfg, config_out);
    reg_read(strap_pkg::REG_CONFIG, rd_val);
    `CHK("reg_config", {22'h0, exp_cfg}, rd_val);
    reg_read(8'h10, rd_val);
    `CHK("reg_unmapped", 32'h0, rd_val);
    reg_read(strap_pkg::REG_CONTROL, rd_val);
    `CHK("reg_control", 32'h0, rd_val);
    // first all floating, then a platform release with the thermal pin low
    for (int i = 0; i < 16; i++)
    begin
      kind = (i < 2) ? i : int'($unsigned($random(seed)) % 3);
      pick = strap_pkg::strap_pins_t'(9'($random(seed)));
      drv  = (i == 0) ? 9'h000 : 9'($random(seed));
      th   = (i == 1) ? 1'b0 : 1'($random(seed));
      exp_cfg = next_cfg(exp_cfg, kind, eff(pick, drv), th);
      caps++;
      board_strap_model_i.event_cycle(kind, pick, drv, th);
      @(negedge clk);
      `CHK("config", exp_cfg, config_out);
      `CHK("tristate", exp_cfg.fault_resilient_boot, output_tristate_en);
      if (kind != 0)
        boot_walk();
      if (i == 1)
      begin
        reg_read(strap_pkg::REG_SEQ, rd_val);
        `CHK("reg_seq", 32'h0000_0310, rd_val);
      end
      // strap and thermal noise with no latching edge must be ignored
      board_strap_model_i.set_straps(~pick, ~drv, ~th);
      repeat (8) @(negedge clk);
      `CHK("config_hold", exp_cfg, config_out);
    end
    reg_read(strap_pkg::REG_CAPTURES, rd_val);
    `CHK("captures", {24'h0, 8'(caps)}, rd_val);
    close_out();
  end
endmodule : test_poweron_strap_latch
